// File: dwm_monitor.sv
/*
 * dwm_monitor: non-latching warning monitor with APB register access.
 * Assumes sensor values come from logic on MCLK_IN; digital input pins are
 * asynchronous and are synchronised here.
 */
// The APB interface to the registers and the address map were left to the implementer.
`default_nettype none

// What this block does
// - Every warning follows its condition and clears itself, no software clear.
// - Bus-off warning while DC bus absent and soft start unfinished.
// - Motor thermal: above 0.9 of max for over 100 ms; clears below 0.88.
// - Mask bit 0: bridge thermal, motor temperature above 0.9 bridge start for over 1 s, clears below 0.88.
// - Regen warning above 0.9 of capability; clears at or below it.
// - Tracking warning while motion monitoring enabled and target not reached.
// - Limit switch warning while either limit input is high.
// - Backup supply warning when outside 18 V to 36 V for 30 ms.
// - Manual mode warning: assigned line low and enable set; clears when line high.
// - Enable attempt warning: enable requested while hardware enable off or bus-off.
// - Bridge limit warning at 90% of fault limit; clears below 88%.
// - Mask bit 1: motor limit, above 0.9 start for over 1 s, clears below 0.88.
// - Mask bit 2: ambient limit, above 0.9 start for over 1 s, clears below 0.88.
// - Ambient thermal: above 0.9 of max for over 1 s, clears below 0.88, unmasked.
// - Card mismatch raises fieldbus warning and keeps fieldbus disabled.
// - Two application warnings set by the user control model.
// - I2T warning above limit; display dot lit while current limiting.
// - IT warning when current-time product exceeds its limit.
// - Warning positions 19 to 32 always read zero.
// - Nonzero warning codes are logged; the code is the number of the lowest active warning.

module dwm_monitor
    import dwm_pkg::*;
#(
    parameter int unsigned MOTOR_CYC  = dwm_pkg::CYC_MOTOR,  // motor thermal delay
    parameter int unsigned LIMIT_CYC  = dwm_pkg::CYC_LIMIT,  // one-second delay
    parameter int unsigned BACKUP_CYC = dwm_pkg::CYC_BACKUP, // backup supply delay
    parameter int unsigned LOG_DEPTH  = 8                    // warning history entries
) (
    input  wire logic                  MCLK_IN,        // 250 MHz clock
    input  wire logic                  RESETN_IN,      // async reset, active low
    input  wire dwm_pkg::dwm_apb_req_t APB_REQ_IN,     // apb request
    output var  dwm_pkg::dwm_apb_rsp_t APB_RSP_OUT,    // apb response
    input  wire dwm_pkg::dwm_sense_t   SENSE_IN,       // measured values
    input  wire logic                  LIMIT_POS_IN,   // positive limit pin
    input  wire logic                  LIMIT_NEG_IN,   // negative limit pin
    input  wire logic                  HW_ENABLE_IN,   // hardware enable pin
    input  wire logic                  AUTO_MAN_IN,    // auto/manual pin, low = manual
    input  wire logic                  CUR_LIMITING_IN, // current limiting active
    output logic [31:0]                WARN_WORD_OUT,  // warning word
    output logic [7:0]                 WARN_CODE_OUT,  // nonzero when a warning is present
    output logic                       SEG_DOT_OUT,    // display decimal point
    output logic                       FB_ENABLE_OUT   // fieldbus may initialise
);
    import dwm_pkg::*;

    localparam int unsigned LOG_AW = (LOG_DEPTH > 1) ? $clog2(LOG_DEPTH) : 1;

    typedef struct packed {
        logic [3:0]                  s1;
        logic [3:0]                  s2;
        logic [3:0]                  s3;
        logic [3:0]                  pin;
        logic [15:0]                 ctrl;
        logic [15:0]                 motor_max;
        logic [15:0]                 bridge_start;
        logic [15:0]                 regen_cap;
        logic [15:0]                 motor_start;
        logic [15:0]                 amb_start;
        logic [15:0]                 amb_max;
        logic [15:0]                 bridge_fault;
        logic [15:0]                 i2t_limit;
        logic [15:0]                 it_limit;
        logic [LOG_AW-1:0]           log_sel;
        logic [LOG_AW-1:0]           log_wp;
        logic [LOG_DEPTH-1:0][7:0]   log_mem;
        logic [CNT_W-1:0]            c_motor;
        logic [CNT_W-1:0]            c_bridge;
        logic [CNT_W-1:0]            c_mlim;
        logic [CNT_W-1:0]            c_alim;
        logic [CNT_W-1:0]            c_amb;
        logic [CNT_W-1:0]            c_backup;
        logic [31:0]                 warn;
        logic [7:0]                  code;
        logic                        dot;
        logic                        fb_en;
        dwm_apb_rsp_t                rsp;
    } dwm_state_t;

    dwm_state_t st_q;
    dwm_state_t st_d;

    // a * den > b * num style comparisons without division
    function automatic logic frac_gt(input logic [15:0] a, input logic [7:0] da,
                                     input logic [15:0] b, input logic [7:0] db);
        logic [23:0] pa;
        logic [23:0] pb;
        pa = a * da;
        pb = b * db;
        return pa > pb;
    endfunction

    function automatic logic frac_lt(input logic [15:0] a, input logic [7:0] da,
                                     input logic [15:0] b, input logic [7:0] db);
        logic [23:0] pa;
        logic [23:0] pb;
        pa = a * da;
        pb = b * db;
        return pa < pb;
    endfunction

    // time qualification: counts while cond holds, saturates at lim
    function automatic logic [CNT_W-1:0] qual_cnt(input logic [CNT_W-1:0] cnt,
                                                  input logic cond,
                                                  input logic [CNT_W-1:0] lim);
        logic [CNT_W-1:0] n;
        n = '0;
        if (cond) begin
            n = (cnt == lim) ? cnt : cnt + 1'b1;
        end
        return n;
    endfunction

    // lowest active warning number, 0 when none
    function automatic logic [7:0] warn_code(input logic [31:0] w);
        logic [7:0] c;
        c = 8'h00;
        for (int i = W_USED - 1; i >= 0; i--) begin
            if (w[i]) begin
                c = 8'(i + 1);
            end
        end
        return c;
    endfunction

    logic [CNT_W-1:0] lim_motor;
    logic [CNT_W-1:0] lim_sec;
    logic [CNT_W-1:0] lim_backup;

    assign lim_motor  = CNT_W'(MOTOR_CYC);
    assign lim_sec    = CNT_W'(LIMIT_CYC);
    assign lim_backup = CNT_W'(BACKUP_CYC);

    always_comb begin
        logic [2:0]  mask;
        logic        hi_motor;
        logic        hi_bridge;
        logic        hi_mlim;
        logic        hi_alim;
        logic        hi_amb;
        logic        out_win;
        logic        wr_en;
        logic        rd_ok;
        logic [31:0] rdata;
        logic [31:0] w;
        logic [7:0]  code_n;

        st_d  = st_q;
        mask  = st_q.ctrl[CTRL_MASK_LSB +: 3];
        w     = st_q.warn;
        rd_ok = 1'b1;
        rdata = 32'h0000_0000;

        // pin synchronisers: a level counts once stages 2 and 3 agree
        st_d.s1 = {AUTO_MAN_IN, HW_ENABLE_IN, LIMIT_NEG_IN, LIMIT_POS_IN};
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        for (int i = 0; i < 4; i++) begin
            if (st_q.s2[i] == st_q.s3[i]) begin
                st_d.pin[i] = st_q.s3[i];
            end
        end

        // time-qualified over-threshold conditions
        hi_motor  = frac_gt(SENSE_IN.motor_temp, HI_DEN, st_q.motor_max, HI_NUM);
        hi_bridge = frac_gt(SENSE_IN.motor_temp, HI_DEN, st_q.bridge_start, HI_NUM) && mask[0];
        hi_mlim   = frac_gt(SENSE_IN.motor_temp, HI_DEN, st_q.motor_start, HI_NUM) && mask[1];
        hi_alim   = frac_gt(SENSE_IN.ambient_temp, HI_DEN, st_q.amb_start, HI_NUM) && mask[2];
        hi_amb    = frac_gt(SENSE_IN.ambient_temp, HI_DEN, st_q.amb_max, HI_NUM);
        out_win   = (SENSE_IN.backup_mv < BACKUP_MIN_MV) || (SENSE_IN.backup_mv > BACKUP_MAX_MV);

        st_d.c_motor  = qual_cnt(st_q.c_motor, hi_motor, lim_motor);
        st_d.c_bridge = qual_cnt(st_q.c_bridge, hi_bridge, lim_sec);
        st_d.c_mlim   = qual_cnt(st_q.c_mlim, hi_mlim, lim_sec);
        st_d.c_alim   = qual_cnt(st_q.c_alim, hi_alim, lim_sec);
        st_d.c_amb    = qual_cnt(st_q.c_amb, hi_amb, lim_sec);
        st_d.c_backup = qual_cnt(st_q.c_backup, out_win, lim_backup);

        // plain conditions follow their cause every cycle
        w[W_BUS_OFF]  = !SENSE_IN.bus_present && !SENSE_IN.softstart_done;
        w[W_REGEN]    = frac_gt(SENSE_IN.regen_power, HI_DEN,
                                st_q.regen_cap, HI_NUM);
        w[W_TRACKING] = st_q.ctrl[CTRL_MOTION_EN] && !SENSE_IN.target_reached;
        w[W_LIMIT_SW] = st_q.pin[0] || st_q.pin[1];
        w[W_BACKUP]   = out_win && (st_q.c_backup == lim_backup);
        w[W_MANUAL]   = st_q.ctrl[CTRL_AUTOMAN_CFG] && !st_q.pin[3]
                        && st_q.ctrl[CTRL_MANUAL_EN];
        w[W_ENABLE_TRY] = SENSE_IN.enable_request
                          && (!st_q.pin[2] || st_q.warn[W_BUS_OFF]);
        w[W_FIELDBUS] = SENSE_IN.fb_card_id != st_q.ctrl[CTRL_FB_ID_LSB +: 8];
        w[W_APP1]     = SENSE_IN.app_warn[0];
        w[W_APP2]     = SENSE_IN.app_warn[1];
        w[W_I2T]      = SENSE_IN.i2t_value > st_q.i2t_limit;
        w[W_IT]       = SENSE_IN.it_value > st_q.it_limit;
        w[31:W_USED]  = '0;

        // hysteresis warnings: set when qualified, clear below the low level
        if (hi_motor && st_q.c_motor == lim_motor) begin
            w[W_MOTOR_THERM] = 1'b1;
        end else if (frac_lt(SENSE_IN.motor_temp, LO_DEN, st_q.motor_max, LO_NUM)) begin
            w[W_MOTOR_THERM] = 1'b0;
        end
        if (!mask[0]) begin
            w[W_BRIDGE_THERM] = 1'b0;
        end else if (hi_bridge && st_q.c_bridge == lim_sec) begin
            w[W_BRIDGE_THERM] = 1'b1;
        end else if (frac_lt(SENSE_IN.motor_temp, LO_DEN, st_q.bridge_start, LO_NUM)) begin
            w[W_BRIDGE_THERM] = 1'b0;
        end
        if (!frac_lt(SENSE_IN.bridge_temp, HI_DEN, st_q.bridge_fault, HI_NUM)) begin
            w[W_BRIDGE_LIMIT] = 1'b1;
        end else if (frac_lt(SENSE_IN.bridge_temp, LO_DEN, st_q.bridge_fault, LO_NUM)) begin
            w[W_BRIDGE_LIMIT] = 1'b0;
        end
        if (!mask[1]) begin
            w[W_MOTOR_LIMIT] = 1'b0;
        end else if (hi_mlim && st_q.c_mlim == lim_sec) begin
            w[W_MOTOR_LIMIT] = 1'b1;
        end else if (frac_lt(SENSE_IN.motor_temp, LO_DEN, st_q.motor_start, LO_NUM)) begin
            w[W_MOTOR_LIMIT] = 1'b0;
        end
        if (!mask[2]) begin
            w[W_AMB_LIMIT] = 1'b0;
        end else if (hi_alim && st_q.c_alim == lim_sec) begin
            w[W_AMB_LIMIT] = 1'b1;
        end else if (frac_lt(SENSE_IN.ambient_temp, LO_DEN, st_q.amb_start, LO_NUM)) begin
            w[W_AMB_LIMIT] = 1'b0;
        end
        if (hi_amb && st_q.c_amb == lim_sec) begin
            w[W_AMB_THERM] = 1'b1;
        end else if (frac_lt(SENSE_IN.ambient_temp, LO_DEN, st_q.amb_max, LO_NUM)) begin
            w[W_AMB_THERM] = 1'b0;
        end

        st_d.warn  = w;
        code_n     = warn_code(w);
        st_d.code  = code_n;
        st_d.dot   = CUR_LIMITING_IN;
        st_d.fb_en = !w[W_FIELDBUS];

        // history: log each new nonzero code
        if (code_n != 8'h00 && code_n != st_q.code) begin
            st_d.log_mem[st_q.log_wp] = code_n;
            st_d.log_wp = (st_q.log_wp == LOG_AW'(LOG_DEPTH - 1)) ? '0 : st_q.log_wp + 1'b1;
        end

        // apb: zero-wait, answer prepared in the setup cycle
        wr_en = APB_REQ_IN.psel && APB_REQ_IN.penable && st_q.rsp.pready
                && APB_REQ_IN.pwrite;
        unique case (APB_REQ_IN.paddr)
            OFS_WARN_WORD:    rdata = st_q.warn;
            OFS_WARN_CODE:    rdata = {24'h00_0000, st_q.code};
            OFS_CTRL:         rdata = {16'h0000, st_q.ctrl};
            OFS_MOTOR_MAX:    rdata = {16'h0000, st_q.motor_max};
            OFS_BRIDGE_START: rdata = {16'h0000, st_q.bridge_start};
            OFS_REGEN_CAP:    rdata = {16'h0000, st_q.regen_cap};
            OFS_MOTOR_START:  rdata = {16'h0000, st_q.motor_start};
            OFS_AMB_START:    rdata = {16'h0000, st_q.amb_start};
            OFS_AMB_MAX:      rdata = {16'h0000, st_q.amb_max};
            OFS_BRIDGE_FAULT: rdata = {16'h0000, st_q.bridge_fault};
            OFS_I2T_LIMIT:    rdata = {16'h0000, st_q.i2t_limit};
            OFS_IT_LIMIT:     rdata = {16'h0000, st_q.it_limit};
            OFS_LOG_SEL:      rdata = 32'(st_q.log_sel);
            OFS_LOG_DATA:     rdata = {24'h00_0000, st_q.log_mem[st_q.log_sel]};
            default:          rd_ok = 1'b0;
        endcase

        if (wr_en) begin
            unique case (APB_REQ_IN.paddr)
                OFS_CTRL:         st_d.ctrl         = APB_REQ_IN.pwdata[15:0];
                OFS_MOTOR_MAX:    st_d.motor_max    = APB_REQ_IN.pwdata[15:0];
                OFS_BRIDGE_START: st_d.bridge_start = APB_REQ_IN.pwdata[15:0];
                OFS_REGEN_CAP:    st_d.regen_cap    = APB_REQ_IN.pwdata[15:0];
                OFS_MOTOR_START:  st_d.motor_start  = APB_REQ_IN.pwdata[15:0];
                OFS_AMB_START:    st_d.amb_start    = APB_REQ_IN.pwdata[15:0];
                OFS_AMB_MAX:      st_d.amb_max      = APB_REQ_IN.pwdata[15:0];
                OFS_BRIDGE_FAULT: st_d.bridge_fault = APB_REQ_IN.pwdata[15:0];
                OFS_I2T_LIMIT:    st_d.i2t_limit    = APB_REQ_IN.pwdata[15:0];
                OFS_IT_LIMIT:     st_d.it_limit     = APB_REQ_IN.pwdata[15:0];
                OFS_LOG_SEL:      st_d.log_sel      = APB_REQ_IN.pwdata[LOG_AW-1:0];
                default:          st_d.log_sel      = st_q.log_sel;
            endcase
        end

        // pready high only in the access cycle following setup
        st_d.rsp.pready  = APB_REQ_IN.psel && !APB_REQ_IN.penable;
        st_d.rsp.pslverr = APB_REQ_IN.psel && !APB_REQ_IN.penable
                           && (!rd_ok || (APB_REQ_IN.pwrite
                               && (APB_REQ_IN.paddr == OFS_WARN_WORD
                                   || APB_REQ_IN.paddr == OFS_WARN_CODE
                                   || APB_REQ_IN.paddr == OFS_LOG_DATA)));
        st_d.rsp.prdata  = (APB_REQ_IN.psel && !APB_REQ_IN.penable
                            && !APB_REQ_IN.pwrite) ? rdata : 32'h0000_0000;
    end

    always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            st_q              <= '0;
            st_q.ctrl         <= CTRL_RESET;
            st_q.motor_max    <= THRESH_RESET;
            st_q.bridge_start <= THRESH_RESET;
            st_q.regen_cap    <= THRESH_RESET;
            st_q.motor_start  <= THRESH_RESET;
            st_q.amb_start    <= THRESH_RESET;
            st_q.amb_max      <= THRESH_RESET;
            st_q.bridge_fault <= THRESH_RESET;
            st_q.i2t_limit    <= THRESH_RESET;
            st_q.it_limit     <= THRESH_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    assign APB_RSP_OUT   = st_q.rsp;
    assign WARN_WORD_OUT = st_q.warn;
    assign WARN_CODE_OUT = st_q.code;
    assign SEG_DOT_OUT   = st_q.dot;
    assign FB_ENABLE_OUT = st_q.fb_en;

endmodule : dwm_monitor

`default_nettype wire

// File: dwm_monitor_checker.sv
/* dwm_monitor_checker: port checks of the warning monitor; bound into dwm_monitor below. */
`default_nettype none
module dwm_monitor_checker (
    input wire logic                  MCLK_IN,       // clock
    input wire logic                  RESETN_IN,     // reset, active low
    input wire dwm_pkg::dwm_apb_req_t APB_REQ_IN,    // apb request
    input wire dwm_pkg::dwm_apb_rsp_t APB_RSP_OUT,   // apb response
    input wire dwm_pkg::dwm_sense_t   SENSE_IN,      // sensor values
    input wire logic                  LIMIT_NEG_IN,  // limit pin
    input wire logic [31:0]           WARN_WORD_OUT, // warning word
    input wire logic [7:0]            WARN_CODE_OUT, // warning code
    input wire logic                  FB_ENABLE_OUT  // fieldbus enable
);
    timeunit 1ns;
    timeprecision 1ps;
    import dwm_pkg::*;
    default clocking cb @(posedge MCLK_IN); endclocking
    default disable iff (!RESETN_IN);
    sequence ack_s; APB_RSP_OUT.pready ##1 !APB_RSP_OUT.pready; endsequence
    ack_once_a: assert property (APB_REQ_IN.psel && !APB_REQ_IN.penable |=> ack_s)
        else $error("ready not one cycle after setup");
    err_rdy_a: assert property (APB_RSP_OUT.pslverr |-> APB_RSP_OUT.pready) else $error("err");
    spare_zero_a: assert property (WARN_WORD_OUT[31:18] == 14'h0) else $error("spare set");
    bus_off_a: assert property (!SENSE_IN.bus_present && !SENSE_IN.softstart_done
        |=> WARN_WORD_OUT[W_BUS_OFF]) else $error("bus-off warning missing");
    bus_clear_a: assert property (SENSE_IN.bus_present || SENSE_IN.softstart_done
        |=> !WARN_WORD_OUT[W_BUS_OFF]) else $error("bus-off warning stuck");
    limit_set_a: assert property (LIMIT_NEG_IN [*8] |=> WARN_WORD_OUT[W_LIMIT_SW])
        else $error("limit warning missing");
    code_zero_a: assert property ((WARN_WORD_OUT == 32'h0) == (WARN_CODE_OUT == 8'h00))
        else $error("code disagrees with word");
    fb_off_a: assert property (FB_ENABLE_OUT |-> !WARN_WORD_OUT[W_FIELDBUS]) else $error("fb");
endmodule // dwm_monitor_checker
bind dwm_monitor dwm_monitor_checker u_chk (.MCLK_IN, .RESETN_IN, .APB_REQ_IN, .APB_RSP_OUT,
    .SENSE_IN, .LIMIT_NEG_IN, .WARN_WORD_OUT, .WARN_CODE_OUT, .FB_ENABLE_OUT);
`default_nettype wire

// File: dwm_pkg.sv
/*
 * dwm_pkg: shared constants and carrier types of the drive warning monitor.
 * Assumes a 250 MHz system clock and a 32-bit APB register bus.
 */
`default_nettype none

package dwm_pkg;

    // clock and time
    localparam int unsigned CLK_KHZ          = 250_000;
    localparam int unsigned T_MOTOR_MS       = 100;
    localparam int unsigned T_LIMIT_MS       = 1000;
    localparam int unsigned T_BACKUP_MS      = 30;
    localparam int unsigned CYC_MOTOR        = T_MOTOR_MS * CLK_KHZ;
    localparam int unsigned CYC_LIMIT        = T_LIMIT_MS * CLK_KHZ;
    localparam int unsigned CYC_BACKUP       = T_BACKUP_MS * CLK_KHZ;
    localparam int unsigned CNT_W            = 28;

    // threshold ratios: 0.9 = 9/10, 0.88 = 22/25
    localparam logic [7:0]  HI_NUM           = 8'h09;
    localparam logic [7:0]  HI_DEN           = 8'h0A;
    localparam logic [7:0]  LO_NUM           = 8'h16;
    localparam logic [7:0]  LO_DEN           = 8'h19;

    // backup supply window in millivolts
    localparam logic [15:0] BACKUP_MIN_MV    = 16'h4650;
    localparam logic [15:0] BACKUP_MAX_MV    = 16'h8CA0;

    // register byte offsets
    localparam logic [7:0]  OFS_WARN_WORD    = 8'h00;
    localparam logic [7:0]  OFS_WARN_CODE    = 8'h04;
    localparam logic [7:0]  OFS_CTRL         = 8'h08;
    localparam logic [7:0]  OFS_MOTOR_MAX    = 8'h10;
    localparam logic [7:0]  OFS_BRIDGE_START = 8'h14;
    localparam logic [7:0]  OFS_REGEN_CAP    = 8'h18;
    localparam logic [7:0]  OFS_MOTOR_START  = 8'h1C;
    localparam logic [7:0]  OFS_AMB_START    = 8'h20;
    localparam logic [7:0]  OFS_AMB_MAX      = 8'h24;
    localparam logic [7:0]  OFS_BRIDGE_FAULT = 8'h28;
    localparam logic [7:0]  OFS_I2T_LIMIT    = 8'h2C;
    localparam logic [7:0]  OFS_IT_LIMIT     = 8'h30;
    localparam logic [7:0]  OFS_LOG_SEL      = 8'h34;
    localparam logic [7:0]  OFS_LOG_DATA     = 8'h38;

    // control register fields
    localparam int unsigned CTRL_MASK_LSB    = 0;
    localparam int unsigned CTRL_MANUAL_EN   = 3;
    localparam int unsigned CTRL_MOTION_EN   = 4;
    localparam int unsigned CTRL_AUTOMAN_CFG = 5;
    localparam int unsigned CTRL_FB_ID_LSB   = 8;
    localparam logic [15:0] CTRL_RESET       = 16'h0000;
    localparam logic [15:0] THRESH_RESET     = 16'hFFFF;

    // warning bit positions (bit n-1 holds warning n)
    localparam int unsigned W_BUS_OFF        = 0;
    localparam int unsigned W_MOTOR_THERM    = 1;
    localparam int unsigned W_BRIDGE_THERM   = 2;
    localparam int unsigned W_REGEN          = 3;
    localparam int unsigned W_TRACKING       = 4;
    localparam int unsigned W_LIMIT_SW       = 5;
    localparam int unsigned W_BACKUP         = 6;
    localparam int unsigned W_MANUAL         = 7;
    localparam int unsigned W_ENABLE_TRY     = 8;
    localparam int unsigned W_BRIDGE_LIMIT   = 9;
    localparam int unsigned W_MOTOR_LIMIT    = 10;
    localparam int unsigned W_AMB_LIMIT      = 11;
    localparam int unsigned W_AMB_THERM      = 12;
    localparam int unsigned W_FIELDBUS       = 13;
    localparam int unsigned W_APP1           = 14;
    localparam int unsigned W_APP2           = 15;
    localparam int unsigned W_I2T            = 16;
    localparam int unsigned W_IT             = 17;
    localparam int unsigned W_USED           = 18;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } dwm_apb_req_t;

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } dwm_apb_rsp_t;

    // measured quantities, all from logic on the same clock
    typedef struct packed {
        logic [15:0] motor_temp;
        logic [15:0] ambient_temp;
        logic [15:0] bridge_temp;
        logic [15:0] regen_power;
        logic [15:0] backup_mv;
        logic [15:0] i2t_value;
        logic [15:0] it_value;
        logic        bus_present;
        logic        softstart_done;
        logic        target_reached;
        logic        enable_request;
        logic [7:0]  fb_card_id;
        logic [1:0]  app_warn;
    } dwm_sense_t;

endpackage : dwm_pkg

`default_nettype wire

// File: tb.sv
/* tb: directed run of the warning monitor; assumes package, design and checker come first. */
`default_nettype none
module tb;
    timeunit 1ns / 1ps;
    import dwm_pkg::*;
    logic         mclk = 1'b0, rst_n = 1'b0, lim_n = 1'b0, hw_en = 1'b1, cur_lim = 1'b0;
    logic         seg, fb_en, err;
    logic [31:0]  word, rdat;
    logic [7:0]   code;
    dwm_apb_req_t req = '0;
    dwm_apb_rsp_t rsp;
    dwm_sense_t   sn = '{enable_request: 1'b1, backup_mv: 16'h5DC0, default: '0};
    int           n_mismatch = 0, n_tests = 0;
    dwm_monitor #(.MOTOR_CYC(20), .LIMIT_CYC(50), .BACKUP_CYC(10)) DUT (.MCLK_IN(mclk),
        .RESETN_IN(rst_n), .APB_REQ_IN(req), .APB_RSP_OUT(rsp), .SENSE_IN(sn),
        .LIMIT_POS_IN(1'b0), .LIMIT_NEG_IN(lim_n), .HW_ENABLE_IN(hw_en), .AUTO_MAN_IN(1'b1),
        .CUR_LIMITING_IN(cur_lim), .WARN_WORD_OUT(word), .WARN_CODE_OUT(code),
        .SEG_DOT_OUT(seg), .FB_ENABLE_OUT(fb_en));
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        req <= '{1'b1, 1'b0, w, a, d};
        @(posedge mclk);
        req.penable <= 1'b1;
        do @(posedge mclk); while (rsp.pready !== 1'b1);
        {err, rdat} = {rsp.pslverr, rsp.prdata};
        req <= '0;
        @(posedge mclk);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) $display("MISMATCH at %0t: got %h want %h", $time, got, exp);
        if (got !== exp) n_mismatch++;
    endtask
    task automatic wk(input int n, input logic [31:0] exp);
        repeat (n) @(posedge mclk);
        chk(word, exp);
    endtask
    task automatic results();
        $display("checks %0d, mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial forever #2 mclk = ~mclk;
    initial begin
        #4us;
        n_mismatch++;
        results();
    end
    initial begin
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
        apb(1'b1, 8'h0C, 32'h0000_0001);
        chk(err, 1'b1);
        apb(1'b0, OFS_WARN_WORD, '0);
        chk(rdat, 32'h0000_0101);
        chk(code, 8'h01);
        $display("test 1 done: access and bus-off");
        apb(1'b1, OFS_REGEN_CAP, 32'h0000_0064);
        apb(1'b1, OFS_MOTOR_MAX, 32'h0000_0064);
        sn <= '{softstart_done: 1'b1, target_reached: 1'b1, enable_request: 1'b1,
            regen_power: 16'h005B, motor_temp: 16'h005B, backup_mv: 16'h5DC0, default: '0};
        wk(3, 32'h0000_0008);
        sn.regen_power <= 16'h005A;
        wk(15, '0);
        wk(6, 32'h0000_0002);
        sn.motor_temp <= 16'h0059;
        wk(3, 32'h0000_0002);
        {lim_n, hw_en, cur_lim, sn.motor_temp, sn.fb_card_id} <= {3'b101, 16'h0057, 8'h5A};
        wk(10, 32'h0000_2120);
        chk(fb_en, 1'b0);
        chk(seg, 1'b1);
        $display("test 2 done: thresholds, pins and fieldbus");
        apb(1'b1, OFS_CTRL, 32'h0000_5A10);
        apb(1'b1, OFS_IT_LIMIT, 32'h0000_0000);
        sn <= '{softstart_done: 1'b1, enable_request: 1'b1, regen_power: 16'h005A,
            motor_temp: 16'h0057, fb_card_id: 8'h5A, app_warn: 2'b11, it_value: 16'h0001,
            default: '0};
        {lim_n, hw_en} <= 2'b01;
        wk(15, 32'h0002_C050);
        apb(1'b0, OFS_WARN_WORD, '0);
        chk(rdat, 32'h0002_C050);
        chk(code, 8'h05);
        chk(fb_en, 1'b1);
        $display("test 3 done: tracking, backup, application and IT");
        results();
    end
endmodule // tb
`default_nettype wire
